// ---- logic/sdf_front_end.v ----
// Step and direction front end with command window, LED sequence and AXI4-Lite registers.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "sdf_consts.vh"
// What this block does
// - Turn step and direction inputs into driver step, direction and microstep outputs.
// - After power-up flash both LEDs together twice.
// - Then blink red slowly for five seconds, then both LEDs off.
// - While red blinks, classify input activity as steps or commands.
// - A command updates a stored setting or runs a device function.
// - After five seconds switch alone to pass-through; commands no longer detected.
// - In pass-through ignore every configuration change except interrupt mask writes; inputs are plain step and direction.
// - Only reset restarts the window; nothing else leaves pass-through.
// - Default microstep mode is quarter step.
// - Default limit recognition on, emergency-stop recognition off.
// - Enabled and asserted limit input halts stepping.
// - Enabled and asserted emergency-stop input halts stepping.
module sdf_front_end #(
  parameter WINDOW_CYC = `SDF_WINDOW_MS * `SDF_CLK_KHZ,
  parameter FLASH_CYC  = `SDF_FLASH_MS * `SDF_CLK_KHZ,
  parameter BLINK_CYC  = `SDF_BLINK_MS * `SDF_CLK_KHZ
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        step_pin,
  input  wire        dir_pin,
  input  wire        limit_pin,
  input  wire        estop_pin,
  output reg         drv_step,
  output reg         drv_dir,
  output reg  [1:0]  drv_mode,
  output reg         led_red,
  output reg         led_green,
  output reg         irq,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // ****************************************
  // Constants and state codes
  // ****************************************
  localparam [31:0] STEP_PW_CYC = (`SDF_STEP_PW_NS * `SDF_CLK_KHZ + 999999) / 1000000;
  localparam [3:0] ST_FLASH  = 4'b0001;
  localparam [3:0] ST_WINDOW = 4'b0010;
  localparam [3:0] ST_PASS   = 4'b0100;
  localparam [3:0] ST_IDLE   = 4'b1000;

  wire [3:0]  pins_sync;
  reg  [3:0]  pins_prev;
  wire        step_rise;
  wire        dir_edge;
  wire        plain_step;
  wire        cmd_valid;
  wire [3:0]  cmd_code;
  reg  [3:0]  state;
  reg  [31:0] timer;
  reg  [31:0] blink_cnt;
  reg  [1:0]  flash_phase;
  reg  [1:0]  step_mode;
  reg         lim_en;
  reg         estop_en;
  reg  [3:0]  last_cmd;
  reg  [3:0]  irq_stat;
  reg  [3:0]  irq_mask;
  reg  [31:0] pw_cnt;
  reg  [3:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;
  wire        in_window;
  wire        halted;
  wire        step_take;
  wire        wr_fire;
  wire        rd_fire;
  wire        rd_stat;
  wire [3:0]  irq_set;

  // ****************************************
  // Input conditioning
  // ****************************************
  sdf_sync #(
    .W (4)
  ) u_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   ({estop_pin, limit_pin, dir_pin, step_pin}),
    .level (pins_sync)
  );

  // Previous filtered levels give clean edges.
  always @(posedge clk) begin
    if (rst) begin
      pins_prev <= 4'h0;
    end else begin
      pins_prev <= pins_sync;
    end
  end

  assign step_rise = pins_sync[0] & ~pins_prev[0];
  assign dir_edge  = pins_sync[1] ^ pins_prev[1];
  assign in_window = (state == ST_WINDOW);
  // Halting is a level: stepping resumes once the input releases.
  assign halted    = (lim_en & pins_sync[2]) | (estop_en & pins_sync[3]);

  // ****************************************
  // Command decoder
  // ****************************************
  // Enabled only inside the window, so pass-through never sees commands.
  sdf_cmd_decoder u_dec (
    .clk        (clk),
    .rst        (rst),
    .enable     (in_window),
    .step_rise  (step_rise),
    .dir_edge   (dir_edge),
    .plain_step (plain_step),
    .cmd_valid  (cmd_valid),
    .cmd_code   (cmd_code)
  );

  // ****************************************
  // Power-up sequence and window timer
  // ****************************************
  // Four flash phases, then the timed window, then pass-through for good.
  always @(posedge clk) begin
    if (rst) begin
      state       <= ST_FLASH;
      timer       <= 32'h00000000;
      flash_phase <= 2'h0;
    end else begin
      case (state)
        ST_FLASH: begin
          if (timer >= FLASH_CYC - 1) begin
            timer       <= 32'h00000000;
            flash_phase <= flash_phase + 2'h1;
            if (flash_phase == 2'h3) begin
              state <= ST_WINDOW;
            end
          end else begin
            timer <= timer + 32'h00000001;
          end
        end
        ST_WINDOW: begin
          if (timer >= WINDOW_CYC - 1) begin
            timer <= 32'h00000000;
            state <= ST_PASS;
          end else begin
            timer <= timer + 32'h00000001;
          end
        end
        ST_PASS: begin
          state <= ST_PASS;
        end
        default: begin
          state <= ST_FLASH;
        end
      endcase
    end
  end

  // Slow red blink runs only in the window.
  always @(posedge clk) begin
    if (rst || !in_window) begin
      blink_cnt <= 32'h00000000;
    end else if (blink_cnt >= BLINK_CYC - 1) begin
      blink_cnt <= 32'h00000000;
    end else begin
      blink_cnt <= blink_cnt + 32'h00000001;
    end
  end

  // LEDs: both on in even flash phases, red toggles in the window, dark after.
  always @(posedge clk) begin
    if (rst) begin
      led_red   <= 1'b0;
      led_green <= 1'b0;
    end else begin
      case (state)
        ST_FLASH: begin
          led_red   <= ~flash_phase[0];
          led_green <= ~flash_phase[0];
        end
        ST_WINDOW: begin
          led_green <= 1'b0;
          if (blink_cnt >= BLINK_CYC - 1) begin
            led_red <= ~led_red;
          end
        end
        default: begin
          led_red   <= 1'b0;
          led_green <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Configuration store
  // ****************************************
  // Commands and control register writes change settings only in the window.
  always @(posedge clk) begin
    if (rst) begin
      step_mode <= `SDF_RST_MODE;
      lim_en    <= `SDF_RST_LIM_EN;
      estop_en  <= `SDF_RST_ESTOP_EN;
      last_cmd  <= 4'h0;
    end else if (in_window && cmd_valid) begin
      last_cmd <= cmd_code;
      case (cmd_code)
        4'h0, 4'h1, 4'h2, 4'h3: begin
          step_mode <= cmd_code[1:0];
        end
        `SDF_CMD_LIM_ON: begin
          lim_en <= 1'b1;
        end
        `SDF_CMD_LIM_OFF: begin
          lim_en <= 1'b0;
        end
        `SDF_CMD_ESTOP_ON: begin
          estop_en <= 1'b1;
        end
        `SDF_CMD_ESTOP_OFF: begin
          estop_en <= 1'b0;
        end
        `SDF_CMD_DEFAULTS: begin
          step_mode <= `SDF_RST_MODE;
          lim_en    <= `SDF_RST_LIM_EN;
          estop_en  <= `SDF_RST_ESTOP_EN;
        end
        default: begin
          last_cmd <= cmd_code;
        end
      endcase
    end else if (in_window && wr_fire && aw_addr == `SDF_REG_CTRL && w_strb[0]) begin
      step_mode <= w_data[`SDF_CTRL_MODE_LO +: 2];
      lim_en    <= w_data[`SDF_CTRL_LIM_EN];
      estop_en  <= w_data[`SDF_CTRL_ESTOP_EN];
    end
  end

  // ****************************************
  // Driver outputs
  // ****************************************
  // In the window only decoder-approved steps pass; after it every rising edge does unless halted.
  assign step_take = ~halted & (in_window ? plain_step : (state == ST_PASS) & step_rise);

  // Fixed-width step pulse; edges inside a pulse are absorbed, so the pulse caps the rate.
  always @(posedge clk) begin
    if (rst) begin
      drv_step <= 1'b0;
      drv_dir  <= 1'b0;
      drv_mode <= `SDF_RST_MODE;
      pw_cnt   <= 32'h00000000;
    end else begin
      drv_mode <= step_mode;
      if (step_take && !drv_step) begin
        drv_step <= 1'b1;
        drv_dir  <= pins_sync[1];
        pw_cnt   <= STEP_PW_CYC - 1;
      end else if (pw_cnt != 32'h00000000) begin
        pw_cnt <= pw_cnt - 32'h00000001;
      end else begin
        drv_step <= 1'b0;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_set[`SDF_IRQ_WIN_END] = in_window && timer >= WINDOW_CYC - 1;
  assign irq_set[`SDF_IRQ_CMD]     = in_window && cmd_valid;
  assign irq_set[`SDF_IRQ_LIMIT]   = lim_en && pins_sync[2] && !pins_prev[2];
  assign irq_set[`SDF_IRQ_ESTOP]   = estop_en && pins_sync[3] && !pins_prev[3];
  assign rd_stat = rd_fire && s_axi_araddr == `SDF_REG_IRQ_STAT;

  // Sticky bits cleared by a status read; a new event in the same cycle wins.
  always @(posedge clk) begin
    if (rst) begin
      irq_stat <= 4'h0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (rd_stat ? 4'h0 : irq_stat) | irq_set;
      irq      <= |(((rd_stat ? 4'h0 : irq_stat) | irq_set) & irq_mask);
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Address and data are caught in either order; the response follows both.
  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SDF_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      irq_mask      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[1:0] == 2'h0) ? `SDF_RESP_OKAY : `SDF_RESP_SLVERR;
        if (aw_addr == `SDF_REG_IRQ_MASK && w_strb[0]) begin
          irq_mask <= w_data[3:0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // One read at a time; arready drops until the data is taken.
  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SDF_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `SDF_RESP_OKAY;
      case (s_axi_araddr)
        `SDF_REG_CTRL: begin
          s_axi_rdata <= {28'h0000000, estop_en, lim_en, step_mode};
        end
        `SDF_REG_STATUS: begin
          s_axi_rdata <= {23'h000000, last_cmd, halted, pins_sync[3:2], state == ST_PASS, in_window};
        end
        `SDF_REG_IRQ_STAT: begin
          s_axi_rdata <= {28'h0000000, irq_stat};
        end
        `SDF_REG_IRQ_MASK: begin
          s_axi_rdata <= {28'h0000000, irq_mask};
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SDF_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // sdf_front_end
`default_nettype wire

// ---- logic/sdf_consts.vh ----
// Constants shared by the step and direction command front end.
`ifndef SDF_CONSTS_VH
`define SDF_CONSTS_VH
// Clock rate in kHz and documented times.
`define SDF_CLK_KHZ       200000
`define SDF_WINDOW_MS     5000
`define SDF_FLASH_MS      250
`define SDF_BLINK_MS      500
`define SDF_STEP_PW_NS    1000
// Register byte offsets.
`define SDF_REG_CTRL      4'h0
`define SDF_REG_STATUS    4'h4
`define SDF_REG_IRQ_STAT  4'h8
`define SDF_REG_IRQ_MASK  4'hc
// Control field positions and reset values.
`define SDF_CTRL_MODE_LO  0
`define SDF_CTRL_LIM_EN   2
`define SDF_CTRL_ESTOP_EN 3
`define SDF_MODE_FULL     2'h0
`define SDF_MODE_HALF     2'h1
`define SDF_MODE_QUARTER  2'h2
`define SDF_MODE_SIXTEEN  2'h3
`define SDF_RST_MODE      2'h2
`define SDF_RST_LIM_EN    1'h1
`define SDF_RST_ESTOP_EN  1'h0
// Interrupt status bit positions.
`define SDF_IRQ_WIN_END   0
`define SDF_IRQ_CMD       1
`define SDF_IRQ_LIMIT     2
`define SDF_IRQ_ESTOP     3
// Command codes delivered by the pattern decoder.
`define SDF_CMD_LIM_ON    4'h4
`define SDF_CMD_LIM_OFF   4'h5
`define SDF_CMD_ESTOP_ON  4'h6
`define SDF_CMD_ESTOP_OFF 4'h7
`define SDF_CMD_DEFAULTS  4'h8
// AXI responses.
`define SDF_RESP_OKAY     2'h0
`define SDF_RESP_SLVERR   2'h2
`endif

// ---- logic/sdf_sync.v ----
// Three flop input synchroniser with agreement filter, one lane per bit.
`timescale 1ns/100ps
`default_nettype none
module sdf_sync #(
  parameter W = 4
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] pin,
  output reg  [W-1:0] level
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  genvar i;
  // ****************************************
  // Per bit chain
  // ****************************************
  generate
    for (i = 0; i < W; i = i + 1) begin : g_lane
      // The first stage feeds only the second; a change counts when stages two and three agree.
      always @(posedge clk) begin
        if (rst) begin
          s1[i]    <= 1'b0;
          s2[i]    <= 1'b0;
          s3[i]    <= 1'b0;
          level[i] <= 1'b0;
        end else begin
          s1[i] <= pin[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            level[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule // sdf_sync
`default_nettype wire

// ---- logic/sdf_cmd_decoder.v ----
// Pluggable pattern decoder telling ordinary steps from encoded commands.
`timescale 1ns/100ps
`default_nettype none
module sdf_cmd_decoder (
  input  wire       clk,
  input  wire       rst,
  input  wire       enable,
  input  wire       step_rise,
  input  wire       dir_edge,
  output reg        plain_step,
  output reg        cmd_valid,
  output reg  [3:0] cmd_code
);
  reg [4:0] toggles;
  // Direction toggles between steps mark a command; toggles minus two is the code.
  // A lone step with fewer than two toggles is an ordinary step. Swap this module to change encoding.
  always @(posedge clk) begin
    if (rst || !enable) begin
      toggles    <= 5'h00;
      plain_step <= 1'b0;
      cmd_valid  <= 1'b0;
      cmd_code   <= 4'h0;
    end else begin
      plain_step <= 1'b0;
      cmd_valid  <= 1'b0;
      if (step_rise) begin
        toggles <= 5'h00;
        if (toggles >= 5'h02 && toggles <= 5'h11) begin
          cmd_valid <= 1'b1;
          cmd_code  <= toggles[3:0] - 4'h2;
        end else if (toggles < 5'h02) begin
          plain_step <= 1'b1;
        end
      end else if (dir_edge && toggles != 5'h1f) begin
        toggles <= toggles + 5'h01;
      end
    end
  end
endmodule // sdf_cmd_decoder
`default_nettype wire

// ---- tb/sdf_ctl_model.sv ----
// Behavioural motion controller that drives the step and direction lines.
`timescale 1ns/100ps
`default_nettype none
module sdf_ctl_model (
  input  wire logic clk,
  output var  logic step_pin,
  output var  logic dir_pin
);
  // Both lines are actively driven at all times; the controller never releases them.
  initial begin
    step_pin = 1'b0;
    dir_pin  = 1'b0;
  end
  // Step pulse; the rest plus the 30 cycles of lead and high time must outlast the 200-cycle driver pulse or the next edge is dropped.
  task automatic pulse(input int rest);
    repeat (10) @(posedge clk);
    step_pin <= 1'b1;
    repeat (20) @(posedge clk);
    step_pin <= 1'b0;
    repeat (rest) @(posedge clk);
  endtask
  // Plain step: at most one direction change, so it never looks like a command.
  task automatic step_once(input logic d, input int rest);
    @(posedge clk);
    dir_pin <= d;
    pulse(rest);
  endtask
  // Command: kk toggles held past the input filter, then the closing step edge.
  task automatic send_cmd(input int kk);
    repeat (kk) begin
      repeat (10) @(posedge clk);
      dir_pin <= ~dir_pin;
    end
    pulse(230);
  endtask
endmodule // sdf_ctl_model
`default_nettype wire

// ---- tb/sdf_props.sv ----
// Concurrent checks on the ports of the step and direction front end.
`timescale 1ns/100ps
`default_nettype none
module sdf_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        drv_step,
  input wire logic        drv_dir,
  input wire logic [1:0]  drv_mode,
  input wire logic        led_red,
  input wire logic        led_green,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Pulse length counter; 200 cycles is far beyond what a repetition may unroll.
  logic [8:0] hi_cnt;
  always_ff @(posedge clk) begin
    if (rst || !drv_step) hi_cnt <= 9'h000;
    else hi_cnt <= hi_cnt + 9'h001;
  end
  a_pulse_width: assert property ($fell(drv_step) |-> hi_cnt == 9'h0c8)
    else $error("driver pulse width wrong");
  a_dir_hold: assert property (drv_step && $past(drv_step) |-> $stable(drv_dir))
    else $error("direction moved inside a pulse");
  a_mode_default: assert property ($fell(rst) |-> drv_mode == 2'h2)
    else $error("mode not quarter after reset");
  a_flash_start: assert property ($fell(rst) |-> ##[1:3] (led_red && led_green))
    else $error("both LEDs not lit after reset");
  a_green_red: assert property (led_green |-> led_red)
    else $error("green LED lit alone");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule // sdf_props
bind sdf_front_end sdf_props u_props (.clk(clk), .rst(rst), .drv_step(drv_step), .drv_dir(drv_dir),
  .drv_mode(drv_mode), .led_red(led_red), .led_green(led_green), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the step and direction front end.
`timescale 1ns/100ps
`default_nettype none
`include "sdf_consts.vh"
module tb;
  // Short counts keep the run brief; the LED and restart waits derive from them except the fixed 175-cycle wait into the window.
  localparam int FL = 50;
  localparam int BL = 100;
  localparam int WN = 6000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        limit_pin = 1'b0;
  logic        estop_pin = 1'b0;
  logic        step_pin, dir_pin, drv_step, drv_dir, led_red, led_green, irq;
  logic [1:0]  drv_mode, bresp, rresp, resp, exp_mode;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, prev_step = 1'b0, last_dir, r0;
  logic        win, exp_lim, exp_est;
  int          n_fail = 0, n_tests = 0, n_pulse = 0, exp_pulse = 0, cyc = 0;
  always #2.5 clk = ~clk;
  sdf_front_end #(.WINDOW_CYC(WN), .FLASH_CYC(FL), .BLINK_CYC(BL)) dut_u (.clk(clk), .rst(rst),
    .step_pin(step_pin), .dir_pin(dir_pin), .limit_pin(limit_pin), .estop_pin(estop_pin), .drv_step(drv_step),
    .drv_dir(drv_dir), .drv_mode(drv_mode), .led_red(led_red), .led_green(led_green), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  sdf_ctl_model ctl (.clk(clk), .step_pin(step_pin), .dir_pin(dir_pin));
  // Pulse counter and hang guard; the direction is noted as each pulse starts.
  always @(posedge clk) begin
    prev_step <= drv_step;
    cyc <= cyc + 1;
    if (drv_step === 1'b1 && prev_step === 1'b0) begin
      n_pulse <= n_pulse + 1;
      last_dir <= drv_dir;
    end
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  //****************************************
  // Shared tasks
  //****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // Response is taken late on purpose so the hold of bvalid gets exercised.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dt, output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end else if (bvalid === 1'b1) bready <= 1'b1;
    end
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] dt);
    bit done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready) begin
        dt = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end else if (rvalid === 1'b1) rready <= 1'b1;
    end
  endtask
  task automatic do_step(input int adds);
    logic d;
    d = 1'($urandom);
    ctl.step_once(d, 230 + int'($urandom % 40));
    exp_pulse += adds;
    chk("pulses", exp_pulse, n_pulse);
    if (adds != 0) chk("dir", d, last_dir);
  endtask
  // Reference model of the settings: commands act only inside the window.
  task automatic do_cmd(input int kk);
    int c;
    c = kk - 2;
    ctl.send_cmd(kk);
    if (!win) exp_pulse++;
    else if (c < 4) exp_mode = 2'(c);
    else if (c < 6) exp_lim = (c == 4);
    else if (c < 8) exp_est = (c == 6);
    else if (c == 8) {exp_est, exp_lim, exp_mode} = 4'h6;
    chk("mode", exp_mode, drv_mode);
    chk("pulses", exp_pulse, n_pulse);
    axi_rd(`SDF_REG_CTRL, rd);
    chk("ctrl", {28'h0, exp_est, exp_lim, exp_mode}, rd);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  //****************************************
  // Main sequence
  //****************************************
  initial begin
    void'($urandom(9988));
    win = 1'b1;
    {exp_est, exp_lim, exp_mode} = 4'h6;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (FL / 2) @(posedge clk);
    chk("leds on", 2'b11, {led_red, led_green});
    repeat (FL) @(posedge clk);
    chk("leds off", 2'b00, {led_red, led_green});
    repeat (175) @(posedge clk);
    r0 = led_red;
    chk("green", 1'b0, led_green);
    repeat (BL) @(posedge clk);
    chk("red blink", !r0, led_red);
    axi_rd(`SDF_REG_CTRL, rd);
    chk("ctrl reset", 32'h6, rd);
    chk("rresp", `SDF_RESP_OKAY, resp);
    axi_rd(4'h1, rd);
    chk("unmapped resp", `SDF_RESP_SLVERR, resp);
    chk("unmapped data", 32'h0, rd);
    // A software write inside the window must land, then the defaults are put back.
    axi_wr(`SDF_REG_CTRL, 32'hb, resp);
    axi_rd(`SDF_REG_CTRL, rd);
    chk("ctrl write", 32'hb, rd);
    chk("mode write", `SDF_MODE_SIXTEEN, drv_mode);
    axi_wr(`SDF_REG_CTRL, 32'h6, resp);
    axi_rd(`SDF_REG_STATUS, rd);
    chk("window", 32'h1, rd & 32'h3);
    axi_wr(`SDF_REG_IRQ_MASK, 32'hf, resp);
    axi_wr(4'h2, 32'h0, resp);
    chk("unaligned", `SDF_RESP_SLVERR, resp);
    do_cmd(2);
    chk("irq", 1'b1, irq);
    axi_rd(`SDF_REG_IRQ_STAT, rd);
    chk("irq stat", 32'h2, rd);
    repeat (3) @(posedge clk);
    chk("irq clear", 1'b0, irq);
    for (int k = 3; k <= 5; k++) do_cmd(k);
    do_cmd(8);
    do_step(1);
    limit_pin <= 1'b1;
    do_step(0);
    limit_pin <= 1'b0;
    estop_pin <= 1'b1;
    do_step(0);
    estop_pin <= 1'b0;
    do_cmd(7);
    limit_pin <= 1'b1;
    do_step(1);
    limit_pin <= 1'b0;
    do_cmd(9);
    do_cmd(10);
    axi_rd(`SDF_REG_IRQ_STAT, rd);
    while (irq !== 1'b1) @(posedge clk);
    win = 1'b0;
    repeat (2) @(posedge clk);
    chk("leds out", 2'b00, {led_red, led_green});
    axi_rd(`SDF_REG_STATUS, rd);
    chk("passthrough", 32'h102, rd & 32'h1ff);
    axi_rd(`SDF_REG_IRQ_STAT, rd);
    chk("window end", 32'h1, rd);
    do_cmd(5);
    do_step(1);
    axi_wr(`SDF_REG_CTRL, 32'h0, resp);
    chk("ctrl resp", `SDF_RESP_OKAY, resp);
    axi_rd(`SDF_REG_CTRL, rd);
    chk("ctrl locked", 32'h6, rd);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (FL * 4 + 20) @(posedge clk);
    axi_rd(`SDF_REG_STATUS, rd);
    chk("window again", 32'h1, rd & 32'h3);
    chk("mode again", 2'h2, drv_mode);
    final_report();
  end
endmodule // tb
`default_nettype wire
